// [plmcld_defines.svh]
/*
 * Register offsets, field positions, reset values, seed constants and
 * timing counts of the modulator configuration and lock detect logic.
 * Assumes a 250 MHz block clock.
 */
`ifndef PLMCLD_DEFINES_SVH
`define PLMCLD_DEFINES_SVH

`define PLMCLD_ADDR_INT        6'h03
`define PLMCLD_ADDR_FRAC       6'h04
`define PLMCLD_ADDR_MODCFG     6'h06
`define PLMCLD_ADDR_LOCKCFG    6'h07
`define PLMCLD_ADDR_STATUS     6'h12

`define PLMCLD_MODCFG_RESET    23'h200b4a
`define PLMCLD_LOCKCFG_RESET   14'h014d

`define PLMCLD_SEED_LSB        0
`define PLMCLD_BYPASS_BIT      7
`define PLMCLD_AUTOMATIC_SEED_LOAD_BIT    8
`define PLMCLD_CORE_EN_BIT     11
`define PLMCLD_WINCNT_LSB      0
`define PLMCLD_LD_EN_BIT       3
`define PLMCLD_WIN_SEL_BIT     6
`define PLMCLD_WIN_DUR_LSB     7
`define PLMCLD_TIMER_SPD_LSB   10
`define PLMCLD_STATUS_LOCK_BIT 1

`define PLMCLD_SEED_ZERO       24'h000000
`define PLMCLD_SEED_LSBONE     24'h000001
`define PLMCLD_SEED_A          24'hb29d08
`define PLMCLD_SEED_B          24'h50f1cd

`define PLMCLD_CLK_PERIOD_PS   4000
`define PLMCLD_ANA_WIN_NS      10
// Longest time: rounds down, counted in half clock periods
`define PLMCLD_ANA_WIN_HALF    ((2 * `PLMCLD_ANA_WIN_NS * 1000) / `PLMCLD_CLK_PERIOD_PS)
`define PLMCLD_ELAPSED_MAX     10'h3ff

`endif

// [plmcld_pkg.sv]
/*
 * Types and shared decode functions of the modulator configuration and
 * lock detect logic. Assumes plmcld_defines.svh is on the include path.
 */
`include "plmcld_defines.svh"

package plmcld_pkg;

	typedef enum logic [2:0] {
		LD_IDLE     = 3'b001,
		LD_WAIT_VCO = 3'b010,
		LD_WAIT_REF = 3'b100
	} plmcld_ld_state_t;

	function automatic logic [23:0] plmcld_seed(input logic [1:0] code);
		unique case (code)
			2'h0: plmcld_seed = `PLMCLD_SEED_ZERO;
			2'h1: plmcld_seed = `PLMCLD_SEED_LSBONE;
			2'h2: plmcld_seed = `PLMCLD_SEED_A;
			2'h3: plmcld_seed = `PLMCLD_SEED_B;
		endcase
	endfunction

	function automatic logic [15:0] plmcld_thresh(input logic [2:0] code);
		unique case (code)
			3'h0: plmcld_thresh = 16'h0005;
			3'h1: plmcld_thresh = 16'h0020;
			3'h2: plmcld_thresh = 16'h0060;
			3'h3: plmcld_thresh = 16'h0100;
			3'h4: plmcld_thresh = 16'h0200;
			3'h5: plmcld_thresh = 16'h0800;
			3'h6: plmcld_thresh = 16'h2000;
			3'h7: plmcld_thresh = 16'hffff;
		endcase
	endfunction

	// Window length in half clock periods
	function automatic logic [10:0] plmcld_win_half(input logic       dig,
	                                                input logic [2:0] dur,
	                                                input logic [1:0] spd);
		if (dig) begin
			plmcld_win_half = (11'h001 << dur) << spd;
		end else begin
			plmcld_win_half = 11'(`PLMCLD_ANA_WIN_HALF);
		end
	endfunction

endpackage

// [plmcld_lock_det.sv]
/*
 * Lock detector: times the gap between reference and divided VCO
 * arrivals, tests it against the window and counts consecutive hits.
 * Assumes arrival pulses are one cycle wide and synchronous to clk.
 */
`timescale 1ns/1ps
`include "plmcld_defines.svh"

module plmcld_lock_det
	import plmcld_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       enable,
	input  wire logic       win_digital,
	input  wire logic [2:0] win_dur,
	input  wire logic [1:0] timer_spd,
	input  wire logic [2:0] wincnt_code,
	input  wire logic       ref_arrive,
	input  wire logic       vco_arrive,
	output logic            locked
);

	plmcld_ld_state_t state_q, state_d;
	logic [9:0]       elapsed_q, elapsed_d;
	logic [15:0]      run_q, run_d;
	logic             locked_q, locked_d;
	logic             meas;
	logic [9:0]       gap;
	logic             in_win;
	logic [16:0]      run_inc;

	assign run_inc = {1'b0, run_q} + 17'h00001;
	// Gap in half periods against window in half periods
	assign in_win = {gap, 1'b0} < plmcld_win_half(win_digital, win_dur,
	                                               timer_spd);

	always_comb begin
		state_d   = state_q;
		elapsed_d = elapsed_q;
		meas      = 1'b0;
		gap       = elapsed_q;
		unique case (state_q)
			LD_IDLE: begin
				// Either edge may lead; only the gap counts
				if (ref_arrive && vco_arrive) begin
					meas = 1'b1;
					gap  = 10'h000;
				end else if (ref_arrive) begin
					state_d   = LD_WAIT_VCO;
					elapsed_d = 10'h001;
				end else if (vco_arrive) begin
					state_d   = LD_WAIT_REF;
					elapsed_d = 10'h001;
				end
			end
			LD_WAIT_VCO, LD_WAIT_REF: begin
				if ((state_q == LD_WAIT_VCO && vco_arrive) ||
				    (state_q == LD_WAIT_REF && ref_arrive) ||
				    elapsed_q == `PLMCLD_ELAPSED_MAX) begin
					meas    = 1'b1;
					state_d = LD_IDLE;
				end else begin
					elapsed_d = elapsed_q + 10'h001;
				end
			end
			default: begin
				state_d = LD_IDLE;
			end
		endcase
		run_d    = run_q;
		locked_d = locked_q;
		if (meas) begin
			if (in_win) begin
				if (run_q != 16'hffff) begin
					run_d = run_inc[15:0];
				end
				if (run_inc >= {1'b0, plmcld_thresh(wincnt_code)}) begin
					locked_d = 1'b1;
				end
			end else begin
				run_d    = 16'h0000;
				locked_d = 1'b0;
			end
		end
		if (!enable) begin
			state_d   = LD_IDLE;
			elapsed_d = 10'h000;
			run_d     = 16'h0000;
			locked_d  = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q   <= LD_IDLE;
			elapsed_q <= 10'h000;
			run_q     <= 16'h0000;
			locked_q  <= 1'b0;
		end else begin
			state_q   <= state_d;
			elapsed_q <= elapsed_d;
			run_q     <= run_d;
			locked_q  <= locked_d;
		end
	end

	assign locked = locked_q;

	a_ld_disable: assert property (
		@(posedge clk) disable iff (!rstn)
		!enable |=> (!locked && run_q == 16'h0000))
		else $error("lock held while detector disabled");

	a_miss_clears: assert property (
		@(posedge clk) disable iff (!rstn)
		(enable && meas && !in_win) |=> (!locked && run_q == 16'h0000))
		else $error("out of window cycle did not clear lock");

	a_lock_count: assert property (
		@(posedge clk) disable iff (!rstn)
		$rose(locked) |->
		({1'b0, $past(run_q)} + 17'h00001 >=
		 {1'b0, plmcld_thresh($past(wincnt_code))}))
		else $error("lock declared before enough hits");

	a_hit_counts: assert property (
		@(posedge clk) disable iff (!rstn)
		(enable && meas && in_win && run_q < 16'h0100) |=>
		(run_q == $past(run_q) + 16'h0001))
		else $error("in window hit not counted");

	c_ref_first: cover property (@(posedge clk) disable iff (!rstn)
		state_q == LD_WAIT_VCO && vco_arrive);
	c_vco_first: cover property (@(posedge clk) disable iff (!rstn)
		state_q == LD_WAIT_REF && ref_arrive);
	c_locked: cover property (@(posedge clk) disable iff (!rstn)
		$rose(locked));

endmodule // plmcld_lock_det

// [plmcld_top.sv]
/*
 * Modulator configuration register, seed staging, divider path select,
 * calibration start decode and lock detect register with status read.
 * Assumes a serial port front end that delivers decoded one-cycle
 * register write and read strobes synchronous to clk.
 */
// Overview of operation
// - The seed field picks zero, one, or one of two fixed 24-bit seeds.
// - Seed writes are only stored and reach the modulator on a frequency change with automatic seed load set.
// - Bit 7 clear routes the modulator to the divider, set bypasses it.
// - In bypass the modulator output is ignored but it is clocked while its reset release is 1.
// - Bit 11 enables the fractional core.
// - Bit 11 decides whether an integer or a fractional write starts calibration.
// - The lock detect enable bit gates every lock detect function.
// - Only the magnitude of the reference to divided VCO gap counts, either may lead.
// - Lock is declared after the programmed run of consecutive in-window cycles.
// - Bit 6 picks the fixed analog window or the digital timer window.
// - Run count codes 0 to 7 map to 5, 32, 96, 256, 512, 2048, 8192, 65535.
// - The digital window runs from half a timer cycle to 64, doubling per code.
// - The lock flag reads as bit 1 of the status register.
`timescale 1ns/1ps
`include "plmcld_defines.svh"

module plmcld_top
	import plmcld_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        reg_wr_en,
	input  wire logic        reg_rd_en,
	input  wire logic [5:0]  reg_addr,
	input  wire logic [23:0] reg_wr_data,
	input  wire logic        ref_arrive,
	input  wire logic        vco_arrive,
	input  wire logic        mod_rst_release,
	input  wire logic [7:0]  mod_out,
	output logic      [23:0] reg_rd_data,
	output logic      [23:0] mod_seed_value,
	output logic             mod_seed_load,
	output logic             mod_clk_enable,
	output logic             modulator_core_enable,
	output logic             div_bypass,
	output logic      [7:0]  div_frac_word,
	output logic             auto_calibration_start,
	output logic             lock_indicator
);

	logic [22:0] modcfg_q, modcfg_d;
	logic [13:0] lockcfg_q, lockcfg_d;
	logic [23:0] rd_q, rd_d;
	logic [23:0] seed_q, seed_d;
	logic        seed_load_q, seed_load_d;
	logic        clk_en_q, clk_en_d;
	logic [7:0]  frac_q, frac_d;
	logic        cal_q, cal_d;
	logic        wr_int;
	logic        wr_frac;
	logic        freq_chg;
	logic        core_en;
	logic        bypass;
	logic        auto_seed;
	logic        locked;

	assign wr_int    = reg_wr_en && reg_addr == `PLMCLD_ADDR_INT;
	assign wr_frac   = reg_wr_en && reg_addr == `PLMCLD_ADDR_FRAC;
	assign core_en   = modcfg_q[`PLMCLD_CORE_EN_BIT];
	assign bypass    = modcfg_q[`PLMCLD_BYPASS_BIT];
	assign auto_seed = modcfg_q[`PLMCLD_AUTOMATIC_SEED_LOAD_BIT];
	// Frequency change executes on the write that starts calibration
	assign freq_chg  = core_en ? wr_frac : wr_int;

	// Register file
	always_comb begin
		modcfg_d  = modcfg_q;
		lockcfg_d = lockcfg_q;
		rd_d      = rd_q;
		if (reg_wr_en && reg_addr == `PLMCLD_ADDR_MODCFG) begin
			modcfg_d = reg_wr_data[22:0];
		end
		if (reg_wr_en && reg_addr == `PLMCLD_ADDR_LOCKCFG) begin
			lockcfg_d = reg_wr_data[13:0];
		end
		if (reg_rd_en) begin
			unique case (reg_addr)
				`PLMCLD_ADDR_MODCFG: rd_d = {1'b0, modcfg_q};
				`PLMCLD_ADDR_LOCKCFG: rd_d = {10'h000, lockcfg_q};
				`PLMCLD_ADDR_STATUS: begin
					rd_d = 24'h000000;
					rd_d[`PLMCLD_STATUS_LOCK_BIT] = locked;
				end
				default: rd_d = 24'h000000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			modcfg_q  <= `PLMCLD_MODCFG_RESET;
			lockcfg_q <= `PLMCLD_LOCKCFG_RESET;
			rd_q      <= 24'h000000;
		end else begin
			modcfg_q  <= modcfg_d;
			lockcfg_q <= lockcfg_d;
			rd_q      <= rd_d;
		end
	end

	// Modulator side
	always_comb begin
		seed_d      = seed_q;
		seed_load_d = 1'b0;
		if (freq_chg && auto_seed) begin
			seed_d      = plmcld_seed(modcfg_q[1:0]);
			seed_load_d = 1'b1;
		end
		// Kept running in bypass so isolation can be tested
		clk_en_d = mod_rst_release;
		frac_d   = bypass ? 8'h00 : mod_out;
		cal_d    = freq_chg;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			seed_q      <= 24'h000000;
			seed_load_q <= 1'b0;
			clk_en_q    <= 1'b0;
			frac_q      <= 8'h00;
			cal_q       <= 1'b0;
		end else begin
			seed_q      <= seed_d;
			seed_load_q <= seed_load_d;
			clk_en_q    <= clk_en_d;
			frac_q      <= frac_d;
			cal_q       <= cal_d;
		end
	end

	plmcld_lock_det u_lock_det (
		.clk         (clk),
		.rstn        (rstn),
		.enable      (lockcfg_q[`PLMCLD_LD_EN_BIT]),
		.win_digital (lockcfg_q[`PLMCLD_WIN_SEL_BIT]),
		.win_dur     (lockcfg_q[`PLMCLD_WIN_DUR_LSB +: 3]),
		.timer_spd   (lockcfg_q[`PLMCLD_TIMER_SPD_LSB +: 2]),
		.wincnt_code (lockcfg_q[`PLMCLD_WINCNT_LSB +: 3]),
		.ref_arrive  (ref_arrive),
		.vco_arrive  (vco_arrive),
		.locked      (locked)
	);

	assign reg_rd_data            = rd_q;
	assign mod_seed_value         = seed_q;
	assign mod_seed_load          = seed_load_q;
	assign mod_clk_enable         = clk_en_q;
	assign modulator_core_enable  = core_en;
	assign div_bypass             = bypass;
	assign div_frac_word          = frac_q;
	assign auto_calibration_start = cal_q;
	assign lock_indicator         = locked;

	a_seed_select: assert property (
		@(posedge clk) disable iff (!rstn)
		mod_seed_load |->
		mod_seed_value == plmcld_seed($past(modcfg_q[1:0])))
		else $error("loaded seed does not match seed code");

	a_seed_deferred: assert property (
		@(posedge clk) disable iff (!rstn)
		!(freq_chg && auto_seed) |=> (!mod_seed_load && $stable(seed_q)))
		else $error("seed reached modulator without frequency change");

	a_seed_loads: assert property (
		@(posedge clk) disable iff (!rstn)
		(freq_chg && auto_seed) |=> mod_seed_load)
		else $error("seed not loaded on frequency change");

	a_path_select: assert property (
		@(posedge clk) disable iff (!rstn)
		(rstn && !bypass) |=> div_frac_word == $past(mod_out))
		else $error("modulator not routed to divider");

	a_bypass_ignore: assert property (
		@(posedge clk) disable iff (!rstn)
		(bypass && mod_rst_release) |=> (div_frac_word == 8'h00 &&
		                                 mod_clk_enable))
		else $error("bypass did not ignore or stopped clocking");

	a_cal_source: assert property (
		@(posedge clk) disable iff (!rstn)
		auto_calibration_start |->
		$past(core_en ? wr_frac : wr_int))
		else $error("calibration started by wrong write");

	a_cal_int: assert property (
		@(posedge clk) disable iff (!rstn)
		(wr_int && !core_en) |=> auto_calibration_start)
		else $error("integer write missed calibration start");

	a_lock_status: assert property (
		@(posedge clk) disable iff (!rstn)
		(reg_rd_en && reg_addr == `PLMCLD_ADDR_STATUS) |=>
		reg_rd_data[`PLMCLD_STATUS_LOCK_BIT] == $past(locked))
		else $error("status read does not show lock flag");

	a_cal_frac: assert property (
		@(posedge clk) disable iff (!rstn)
		(wr_frac && core_en) |=> auto_calibration_start)
		else $error("fractional write missed calibration start");

	a_cal_int_skip: assert property (
		@(posedge clk) disable iff (!rstn)
		(wr_int && core_en) |=> !auto_calibration_start)
		else $error("integer write started calibration in frac mode");

	a_clk_release: assert property (
		@(posedge clk) disable iff (!rstn)
		mod_rst_release |=> mod_clk_enable)
		else $error("modulator not clocked while released");

	c_seed_load: cover property (@(posedge clk) disable iff (!rstn)
		mod_seed_load);
	c_frac_cal: cover property (@(posedge clk) disable iff (!rstn)
		core_en && wr_frac ##1 auto_calibration_start);

endmodule // plmcld_top

// [plmcld_host.sv]
/*
 * Host model on the register port: one write task and one read task.
 * Assumes decoded one-cycle strobes sampled on the rising clock.
 */
`timescale 1ns/1ps

module plmcld_host (
	input  wire logic        clk,
	input  wire logic [23:0] reg_rd_data,
	output logic             reg_wr_en,
	output logic             reg_rd_en,
	output logic      [5:0]  reg_addr,
	output logic      [23:0] reg_wr_data
);
	initial begin
		reg_wr_en   = 1'b0;
		reg_rd_en   = 1'b0;
		reg_addr    = 6'h00;
		reg_wr_data = 24'h000000;
	end

	task automatic wr(input logic [5:0] a, input logic [23:0] d);
		@(posedge clk);
		reg_wr_en   <= 1'b1;
		reg_addr    <= a;
		reg_wr_data <= d;
		@(posedge clk);
		reg_wr_en   <= 1'b0;
		// Released data must not look like a held value
		reg_wr_data <= ~d;
	endtask

	task automatic rd(input logic [5:0] a, output logic [23:0] d);
		@(posedge clk);
		reg_rd_en <= 1'b1;
		reg_addr  <= a;
		@(posedge clk);
		reg_rd_en <= 1'b0;
		@(posedge clk);
		#1 d = reg_rd_data;
	endtask
endmodule // plmcld_host

// [tb_top.sv]
/*
 * Self-checking bench of the modulator configuration and lock detect.
 * Assumes plmcld_defines.svh on the include path and the host model.
 */
`timescale 1ns/1ps
`include "plmcld_defines.svh"

module tb_top;
	typedef struct {
		logic [23:0] cfg;
		logic [5:0]  fa;
		logic        cal;
		logic        ld;
		logic [23:0] seed;
		int          hit;
		int          miss;
		int          n;
	} plmcld_row_t;

	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        ref_arrive = 1'b0;
	logic        vco_arrive = 1'b0;
	logic        mod_rst_release = 1'b0;
	logic [7:0]  mod_out = 8'h00;
	logic        reg_wr_en;
	logic        reg_rd_en;
	logic [5:0]  reg_addr;
	logic [23:0] reg_wr_data;
	logic [23:0] reg_rd_data;
	logic [23:0] mod_seed_value;
	logic        mod_seed_load;
	logic        mod_clk_enable;
	logic        modulator_core_enable;
	logic        div_bypass;
	logic [7:0]  div_frac_word;
	logic        auto_calibration_start;
	logic        lock_indicator;
	logic [23:0] rdv;
	int          failures = 0;
	int          tests_run = 0;

	// Seed rows (n of 0): config, frequency write address, calibration
	// start, seed load, seed; window rows: config, hit gap, miss gap, run
	plmcld_row_t rows [14] = '{
		'{24'h000902, 6'h04, 1'b1, 1'b1, `PLMCLD_SEED_A, 0, 0, 0},
		'{24'h000903, 6'h04, 1'b1, 1'b1, `PLMCLD_SEED_B, 0, 0, 0},
		'{24'h000900, 6'h04, 1'b1, 1'b1, `PLMCLD_SEED_ZERO, 0, 0, 0},
		'{24'h000801, 6'h04, 1'b1, 1'b0, `PLMCLD_SEED_ZERO, 0, 0, 0},
		'{24'h000901, 6'h03, 1'b0, 1'b0, `PLMCLD_SEED_ZERO, 0, 0, 0},
		'{24'h000181, 6'h04, 1'b0, 1'b0, `PLMCLD_SEED_ZERO, 0, 0, 0},
		'{24'h000181, 6'h03, 1'b1, 1'b1, `PLMCLD_SEED_LSBONE, 0, 0, 0},
		'{24'h000182, 6'h03, 1'b1, 1'b1, `PLMCLD_SEED_A, 0, 0, 0},
		'{24'h000148, 6'h00, 1'b0, 1'b0, `PLMCLD_SEED_ZERO, 1, 2, 5},
		'{24'h000149, 6'h00, 1'b0, 1'b0, `PLMCLD_SEED_ZERO, 1, 2, 32},
		'{24'h00014a, 6'h00, 1'b0, 1'b0, `PLMCLD_SEED_ZERO, 1, 2, 96},
		'{24'h0003c8, 6'h00, 1'b0, 1'b0, `PLMCLD_SEED_ZERO, 63, 64, 5},
		'{24'h0005c8, 6'h00, 1'b0, 1'b0, `PLMCLD_SEED_ZERO, 7, 8, 5},
		// Analog row: pairs 28 ns or more apart, under 50 MHz
		'{24'h000108, 6'h00, 1'b0, 1'b0, `PLMCLD_SEED_ZERO, 2, 3, 5}};

	always #2 clk = ~clk;

	plmcld_host host (
		.clk         (clk),
		.reg_rd_data (reg_rd_data),
		.reg_wr_en   (reg_wr_en),
		.reg_rd_en   (reg_rd_en),
		.reg_addr    (reg_addr),
		.reg_wr_data (reg_wr_data)
	);

	plmcld_top DUT (
		.clk                    (clk),
		.rstn                   (rstn),
		.reg_wr_en              (reg_wr_en),
		.reg_rd_en              (reg_rd_en),
		.reg_addr               (reg_addr),
		.reg_wr_data            (reg_wr_data),
		.ref_arrive             (ref_arrive),
		.vco_arrive             (vco_arrive),
		.mod_rst_release        (mod_rst_release),
		.mod_out                (mod_out),
		.reg_rd_data            (reg_rd_data),
		.mod_seed_value         (mod_seed_value),
		.mod_seed_load          (mod_seed_load),
		.mod_clk_enable         (mod_clk_enable),
		.modulator_core_enable  (modulator_core_enable),
		.div_bypass             (div_bypass),
		.div_frac_word          (div_frac_word),
		.auto_calibration_start (auto_calibration_start),
		.lock_indicator         (lock_indicator)
	);

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// One arrival pair, g cycles apart, vf chooses which edge leads
	task automatic pair(input int g, input logic vf);
		@(posedge clk);
		ref_arrive <= !vf;
		vco_arrive <= vf;
		repeat (g - 1) begin
			@(posedge clk);
			ref_arrive <= 1'b0;
			vco_arrive <= 1'b0;
		end
		@(posedge clk);
		ref_arrive <= vf;
		vco_arrive <= !vf;
		@(posedge clk);
		ref_arrive <= 1'b0;
		vco_arrive <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	task automatic lk(input logic e);
		#1 chk(24'(lock_indicator), 24'(e));
	endtask

	// Seed row: stage the code, then fire a frequency write
	task automatic seed_row(input plmcld_row_t r);
		host.wr(6'h06, r.cfg);
		#1 chk(24'(mod_seed_load), 24'h000000);
		chk(24'({modulator_core_enable, div_bypass}),
			24'({r.cfg[11], r.cfg[7]}));
		host.wr(r.fa, 24'h000010);
		#1 chk(24'({auto_calibration_start, mod_seed_load}),
			24'({r.cal, r.ld}));
		chk(mod_seed_value, r.seed);
		host.rd(6'h06, rdv);
		chk(rdv, r.cfg);
	endtask

	// Window row: a run of hits locks, one miss drops the lock
	task automatic win_row(input plmcld_row_t r);
		host.wr(6'h07, r.cfg);
		for (int i = 0; i < r.n; i++) begin
			pair(r.hit, i[0]);
			if (i == r.n - 2) begin
				lk(1'b0);
			end
		end
		lk(1'b1);
		host.rd(6'h12, rdv);
		chk(24'(rdv[1]), 24'h000001);
		pair(r.miss, 1'b1);
		lk(1'b0);
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		failures++;
		results();
	end

	initial begin
		repeat (19) @(posedge clk);
		#1 chk(24'({modulator_core_enable, div_bypass, lock_indicator,
			mod_seed_load, auto_calibration_start}), 24'h000010);
		@(posedge clk);
		rstn <= 1'b1;
		host.rd(6'h06, rdv);
		chk(rdv, 24'h200b4a);
		host.rd(6'h07, rdv);
		chk(rdv, 24'h00014d);
		host.rd(6'h3f, rdv);
		chk(rdv, 24'h000000);
		foreach (rows[k]) begin
			if (rows[k].n == 0) begin
				seed_row(rows[k]);
			end else begin
				win_row(rows[k]);
			end
		end
		@(posedge clk);
		mod_out <= 8'ha5;
		mod_rst_release <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk(24'(div_frac_word), 24'h000000);
		chk(24'(mod_clk_enable), 24'h000001);
		host.wr(6'h06, 24'h000902);
		@(posedge clk);
		#1 chk(24'(div_frac_word), 24'h0000a5);
		@(posedge clk);
		mod_rst_release <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk(24'(mod_clk_enable), 24'h000000);
		host.wr(6'h07, 24'h000148);
		repeat (4) pair(1, 1'b0);
		pair(2, 1'b0);
		repeat (4) pair(1, 1'b1);
		lk(1'b0);
		pair(1, 1'b0);
		lk(1'b1);
		host.wr(6'h07, 24'h000140);
		@(posedge clk);
		lk(1'b0);
		repeat (5) pair(1, 1'b0);
		lk(1'b0);
		// Relock, then reset in mid-run
		host.wr(6'h07, 24'h000148);
		repeat (5) pair(1, 1'b1);
		lk(1'b1);
		@(posedge clk);
		rstn <= 1'b0;
		@(posedge clk);
		#1 chk(24'({modulator_core_enable, div_bypass, lock_indicator,
			mod_seed_load, auto_calibration_start}), 24'h000010);
		@(posedge clk);
		rstn <= 1'b1;
		host.rd(6'h06, rdv);
		chk(rdv, 24'h200b4a);
		host.rd(6'h07, rdv);
		chk(rdv, 24'h00014d);
		host.wr(6'h04, 24'h000010);
		#1 chk(24'({auto_calibration_start, mod_seed_load}),
			24'h000003);
		chk(mod_seed_value, `PLMCLD_SEED_A);
		results();
	end
endmodule // tb_top
